// [design/gsr_cfg.svh]
`ifndef GSR_CFG_SVH
`define GSR_CFG_SVH

// ----------------------------------------
// shift chain
// ----------------------------------------
`define GSR_STAGES 8
`define GSR_STAGE_RST 8'h00

// ----------------------------------------
// snapshot buffer
// ----------------------------------------
`define GSR_FIFO_DEPTH 16
`define GSR_FIFO_AW 4

`endif

// [design/gsr_pkg.sv]
`include "gsr_cfg.svh"

package gsr_pkg;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef logic [`GSR_STAGES-1:0] gsr_word_t;

  typedef struct packed {
    logic serial_a;
    logic serial_b;
  } gsr_serial_s;

  typedef struct packed {
    logic overflow;
    gsr_word_t word;
  } gsr_snap_s;

endpackage

// [design/gsr_shift8.sv]
`timescale 1ns/100ps
`include "gsr_cfg.svh"

// ----------------------------------------
// generic fifo
// ----------------------------------------
module gsr_fifo
  import gsr_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = `GSR_FIFO_DEPTH,
  parameter int AW = `GSR_FIFO_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire full = (count_q == DEPTH[AW:0]);
  wire empty = (count_q == '0);

  function automatic logic [AW-1:0] ptr_next(logic [AW-1:0] ptr, logic step);
    return ptr + AW'(step);
  endfunction

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_q];
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= ptr_next(wr_ptr_q, push);
      rd_ptr_q <= ptr_next(rd_ptr_q, pop);
      count_q <= count_d;
    end
  end
endmodule

// ----------------------------------------
// gated serial entry
// ----------------------------------------
module gsr_entry_gate
  import gsr_pkg::*;
(
  // serial inputs
  input wire gsr_serial_s serial_in,
  // first-stage bit
  output logic entry_bit
);
  assign entry_bit = serial_in.serial_a & serial_in.serial_b;
endmodule

// ----------------------------------------
// stage chain
// ----------------------------------------
module gsr_stage_chain
  import gsr_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic async_clear_n,
  // first-stage bit
  input wire logic entry_bit,
  // stage contents
  output gsr_word_t word_q,
  output gsr_word_t word_d
);
  gsr_word_t chain_q;

  function automatic gsr_word_t shift_in(gsr_word_t word, logic bit_in);
    return {word[`GSR_STAGES-2:0], bit_in};
  endfunction

  assign word_d = shift_in(chain_q, entry_bit);
  assign word_q = chain_q;

  // ----------------------------------------
  // stage register
  // ----------------------------------------
  // clear, sync reset, shift on every rising edge
  always_ff @(posedge clk or negedge async_clear_n) begin
    if (!async_clear_n) begin
      chain_q <= `GSR_STAGE_RST;
    end else if (reset) begin
      chain_q <= `GSR_STAGE_RST;
    end else begin
      chain_q <= word_d;
    end
  end
endmodule

// ----------------------------------------
// gap flag
// ----------------------------------------
module gsr_gap_flag
  import gsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // push outcome
  input wire logic refused,
  input wire logic taken,
  // gap marker
  output logic gap_q
);
  logic gap_d;

  // refusal wins; cleared only once a word carries it
  assign gap_d = refused ? 1'b1 : (taken ? 1'b0 : gap_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
    end
  end
endmodule

// ----------------------------------------
// snapshot output register
// ----------------------------------------
module gsr_snap_reg
  import gsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // from buffer
  input wire logic load,
  input wire gsr_snap_s load_data,
  // consumer side
  input wire logic taken,
  output logic valid_q,
  output gsr_snap_s data_q
);
  // load wins over a take: back-to-back words without a bubble
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_q <= 1'b0;
      data_q <= '0;
    end else if (load) begin
      valid_q <= 1'b1;
      data_q <= load_data;
    end else if (taken) begin
      valid_q <= 1'b0;
    end
  end
endmodule

// ----------------------------------------
// gated serial-in parallel-out shifter
// ----------------------------------------
module gsr_shift8
  import gsr_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic async_clear_n,
  // serial inputs
  input wire gsr_serial_s serial_in,
  // parallel outputs
  output gsr_word_t stage_out,
  output logic stage_out_first,
  output logic stage_out_seventh,
  output logic stage_out_last,
  // snapshot stream
  output logic snap_valid,
  input wire logic snap_ready,
  output gsr_snap_s snap_data
);
  gsr_word_t stage_q;
  gsr_word_t stage_d;
  logic gated_bit;
  logic lost_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  gsr_snap_s fifo_in;
  gsr_snap_s fifo_out;
  logic snap_valid_q;
  gsr_snap_s snap_data_q;
  wire load_out = fifo_out_valid && (!snap_valid_q || snap_ready);
  wire push_refused = async_clear_n && !fifo_in_ready;
  wire push_taken = async_clear_n && fifo_in_ready;

  // ----------------------------------------
  // entry gate
  // ----------------------------------------
  // and-gated entry
  gsr_entry_gate u_entry_gate (
    .serial_in(serial_in),
    .entry_bit(gated_bit)
  );

  // ----------------------------------------
  // shift chain
  // ----------------------------------------
  // clear, reset, shift
  gsr_stage_chain u_stage_chain (
    .clk(clk),
    .reset(reset),
    .async_clear_n(async_clear_n),
    .entry_bit(gated_bit),
    .word_q(stage_q),
    .word_d(stage_d)
  );

  assign stage_out = stage_q;
  assign stage_out_first = stage_q[0];
  assign stage_out_seventh = stage_q[`GSR_STAGES-2];
  assign stage_out_last = stage_q[`GSR_STAGES-1];

  // ----------------------------------------
  // snapshot buffer
  // ----------------------------------------
  // word after each shift; marks that earlier words were dropped when full
  assign fifo_in = '{overflow: lost_q, word: stage_d};

  gsr_gap_flag u_gap_flag (
    .clk(clk),
    .reset(reset),
    .refused(push_refused),
    .taken(push_taken),
    .gap_q(lost_q)
  );

  gsr_fifo #(
    .WIDTH($bits(gsr_snap_s)),
    .DEPTH(`GSR_FIFO_DEPTH),
    .AW(`GSR_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(async_clear_n),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(load_out),
    .out_data(fifo_out)
  );

  // ----------------------------------------
  // output register
  // ----------------------------------------
  gsr_snap_reg u_snap_reg (
    .clk(clk),
    .reset(reset),
    .load(load_out),
    .load_data(fifo_out),
    .taken(snap_ready),
    .valid_q(snap_valid_q),
    .data_q(snap_data_q)
  );

  assign snap_valid = snap_valid_q;
  assign snap_data = snap_data_q;
endmodule

// [tb/gsr_host.sv]
`timescale 1ns/100ps
module gsr_host
  import gsr_pkg::*;
(
  // bench and design side
  input wire logic clk,
  input wire logic stall,
  input wire logic fill,
  input wire logic [2:0] rnd,
  output gsr_serial_s serial_in,
  output logic snap_ready
);
  initial {serial_in, snap_ready} = 3'h0;
  always @(posedge clk) begin
    serial_in <= fill ? 2'h3 : rnd[2:1];
    snap_ready <= rnd[0] & !stall;
  end
endmodule

// [tb/gsr_monitor.sv]
`timescale 1ns/100ps
module gsr_monitor
  import gsr_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic async_clear_n,
  input wire gsr_serial_s serial_in,
  input wire gsr_word_t stage_out,
  input wire logic stage_out_first,
  input wire logic stage_out_seventh,
  input wire logic stage_out_last,
  input wire logic snap_valid,
  input wire logic snap_ready,
  input wire gsr_snap_s snap_data
);
  gsr_word_t mid_q;
  always_ff @(negedge clk) mid_q <= stage_out;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_run;
    async_clear_n && $past(async_clear_n) && !$past(reset);
  endsequence
  a_taps_match: assert property (
    {stage_out_last, stage_out_seventh, stage_out_first} == {stage_out[7:6], stage_out[0]})
    else $error("taps");
  a_clear_zero: assert property (!async_clear_n |-> stage_out == 8'h00)
    else $error("clear");
  a_first_and: assert property (s_run |-> stage_out[0] == &$past(serial_in))
    else $error("first");
  a_hold_level: assert property (
    async_clear_n && $past(async_clear_n) |-> stage_out == mid_q) else $error("hold");
  a_shift_one: assert property (s_run |-> stage_out[7:1] == 7'($past(stage_out)))
    else $error("shift");
  a_reset_zero: assert property ($past(reset) |-> stage_out == 8'h00)
    else $error("reset");
  a_snap_hold: assert property (snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
    else $error("snap");
  c_full: cover property (stage_out == 8'hFF);
  c_clear: cover property (!async_clear_n);
  c_ovf: cover property (snap_valid && snap_ready && snap_data.overflow);
endmodule
bind gsr_shift8 gsr_monitor u_gsr_monitor (.*);

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import gsr_pkg::*;
  logic clk = 1'h0, reset = 1'h1, async_clear_n = 1'h1, stall = 1'h0, ovf_q = 1'h0;
  logic ready, valid, first, seventh, last;
  localparam int FIFO_WORDS = 16;
  logic fill = 1'h0;
  logic [2:0] rnd = 3'h0;
  gsr_snap_s fq[$];
  gsr_snap_s held = '0;
  logic held_v = 1'h0, lost_m = 1'h0, full_m = 1'h0;
  gsr_serial_s serial_in;
  gsr_word_t stage_out, exp_q = 8'h00;
  gsr_snap_s snap_data;
  int err_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  gsr_host u_gsr_host (.clk(clk), .stall(stall), .fill(fill), .rnd(rnd),
    .serial_in(serial_in), .snap_ready(ready));
  gsr_shift8 u_gsr_shift8 (.clk(clk), .reset(reset), .async_clear_n(async_clear_n),
    .serial_in(serial_in), .stage_out(stage_out), .stage_out_first(first),
    .stage_out_seventh(seventh), .stage_out_last(last), .snap_valid(valid),
    .snap_ready(ready), .snap_data(snap_data));
  function automatic gsr_word_t shift_next(gsr_word_t w, gsr_serial_s s);
    return {w[6:0], s.serial_a & s.serial_b};
  endfunction
  task automatic cmp_word(string what, gsr_word_t e, gsr_word_t s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, e, s);
    end
  endtask
  task automatic cmp_snap(string what, gsr_snap_s e, gsr_snap_s s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, e, s);
    end
  endtask
  task automatic cmp_bit(string what, logic e, logic s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %b got %b", what, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    exp_q <= (reset || !async_clear_n) ? 8'h00 : shift_next(exp_q, serial_in);
    if (valid && ready) ovf_q <= ovf_q | snap_data.overflow;
    // buffer model: full is judged before this edge's pop
    if (reset) begin
      fq.delete();
      held_v = 1'h0;
      lost_m = 1'h0;
    end else begin
      full_m = (fq.size() == FIFO_WORDS);
      cmp_bit("snap_valid", held_v, valid);
      if (held_v && ready) cmp_snap("snap_data", held, snap_data);
      if (fq.size() != 0 && (!held_v || ready)) begin
        held = fq.pop_front();
        held_v = 1'h1;
      end else if (ready) begin
        held_v = 1'h0;
      end
      if (async_clear_n && full_m) begin
        lost_m = 1'h1;
      end else if (async_clear_n) begin
        fq.push_back('{overflow: lost_m, word: shift_next(exp_q, serial_in)});
        lost_m = 1'h0;
      end
    end
  end
  always @(negedge clk) if (!reset) begin
    cmp_word("stage", async_clear_n ? exp_q : 8'h00, stage_out);
    cmp_word("taps", {5'h00, stage_out[7:6], stage_out[0]}, {5'h00, last, seventh, first});
  end
  initial begin
    void'($urandom(8992));
    fork
      forever begin
        @(posedge clk);
        rnd <= 3'($urandom);
      end
    join_none
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    // corner: both inputs high fill every stage
    fill <= 1'h1;
    repeat (10) @(posedge clk);
    fill <= 1'h0;
    repeat (300) @(posedge clk);
    // consumer stalls for 40 cycles, well past the point where the buffer refuses
    stall <= 1'h1;
    repeat (40) @(posedge clk);
    // clear holds pushes off while the buffer drains
    {stall, async_clear_n} <= 2'h0;
    repeat (40) @(posedge clk);
    async_clear_n <= 1'h1;
    repeat (100) @(posedge clk);
    cmp_bit("overflow", 1'h1, ovf_q);
    reset <= 1'h1;
    @(posedge clk);
    reset <= 1'h0;
    repeat (50) @(posedge clk);
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule
